// ===== core/uhfi_pkg.sv
// Package for the interrupt mask clear and frame length block.
// Assumes a command-code register port as seen by host software.
`default_nettype none
package uhfi_pkg;
   // ----------------------------------------
   // Command codes
   // ----------------------------------------
   localparam logic [7:0] CMD_MASK_RD = 8'h05;
   localparam logic [7:0] CMD_MASK_WR = 8'h85;
   localparam logic [7:0] CMD_FLC_RD = 8'h0d;
   localparam logic [7:0] CMD_FLC_WR = 8'h8d;
   // ----------------------------------------
   // Field layout and reset values
   // ----------------------------------------
   localparam int MASTER_BIT = 31;
   localparam logic [31:0] MASK_EVENT_BITS = 32'h0000007d;
   localparam logic [31:0] MASK_RST = 32'h80000000;
   localparam int TOGGLE_BIT = 31;
   localparam int BUDGET_LSB = 16;
   localparam int BUDGET_W = 15;
   localparam int LEN_W = 14;
   localparam logic [31:0] FLC_RST = 32'h00002edf;
   localparam logic [13:0] LEN_DEFAULT = 14'h2edf;
   // One bit time of 200/12 = 16 clocks at 200 MHz, so 12.5 Mbit/s
   localparam int CLK_MHZ = 200;
   localparam int BIT_MHZ = 12;
   localparam int BIT_DIV = CLK_MHZ / BIT_MHZ;
   localparam logic [4:0] BIT_DIV_M1 = 5'(BIT_DIV - 1);
   typedef enum logic [1:0] {
      UHFI_ST_IDLE = 2'b01,
      UHFI_ST_RUN = 2'b10
   } uhfi_state_t;
endpackage
`default_nettype wire

// ===== core/uhfi_cnt_if.sv
// Carries frame counter signals between the register and counter modules.
// Assumes one clock domain.
`timescale 1ns/1ps
`default_nettype none
interface uhfi_cnt_if;
   logic [13:0] frame_length;
   logic interval_toggle;
   logic [14:0] packet_bit_budget;
   logic frame_start_event;
   logic [13:0] frame_bits_left;
   logic remaining_toggle;
   logic [14:0] packet_budget_counter;
   modport regs (output frame_length, interval_toggle, packet_bit_budget,
      input frame_start_event, frame_bits_left, remaining_toggle,
      packet_budget_counter);
   modport cnt (input frame_length, interval_toggle, packet_bit_budget,
      output frame_start_event, frame_bits_left, remaining_toggle,
      packet_budget_counter);
endinterface
`default_nettype wire

// ===== core/uhfi_frame_cnt.sv
// Frame bit-time counter with toggle copy and packet budget load.
// Assumes i_run comes from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module uhfi_frame_cnt (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Control
   input wire logic i_run,
   uhfi_cnt_if.cnt cnt
);
   typedef struct packed {
      uhfi_pkg::uhfi_state_t st;
      logic [4:0] div;
      logic [13:0] left;
      logic tog;
      logic [14:0] budget;
      logic sof;
   } uhfi_cnt_t;
   uhfi_cnt_t s_r, s_nxt;
   logic bit_en;

   assign bit_en = (s_r.div == uhfi_pkg::BIT_DIV_M1);

   always_comb begin
      s_nxt = s_r;
      s_nxt.sof = 1'b0;
      s_nxt.div = bit_en ? 5'h00 : s_r.div + 5'h01;
      unique case (s_r.st)
         uhfi_pkg::UHFI_ST_IDLE: begin
            if (i_run) begin
               s_nxt.st = uhfi_pkg::UHFI_ST_RUN;
               s_nxt.left = cnt.frame_length;
               s_nxt.budget = cnt.packet_bit_budget;
               s_nxt.sof = 1'b1;
            end
         end
         uhfi_pkg::UHFI_ST_RUN: begin
            if (!i_run) begin
               s_nxt.st = uhfi_pkg::UHFI_ST_IDLE;
            end else if (bit_en) begin
               if (s_r.left == 14'h0000) begin
                  s_nxt.left = cnt.frame_length;
                  s_nxt.tog = cnt.interval_toggle;
                  s_nxt.budget = cnt.packet_bit_budget;
                  s_nxt.sof = 1'b1;
               end else begin
                  s_nxt.left = s_r.left - 14'h0001;
               end
            end
         end
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_r <= '{uhfi_pkg::UHFI_ST_IDLE, 5'h00, 14'h0000, 1'b0,
            15'h0000, 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cnt.frame_start_event = s_r.sof;
   assign cnt.frame_bits_left = s_r.left;
   assign cnt.remaining_toggle = s_r.tog;
   assign cnt.packet_budget_counter = s_r.budget;

   a_reload_len: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (s_r.st == uhfi_pkg::UHFI_ST_RUN) && i_run && bit_en
      && s_r.left == 14'h0000 |=> s_r.left == $past(cnt.frame_length)
      && s_r.sof)
      else $error("Frame counter did not reload");
   a_toggle_copy: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      (s_r.st == uhfi_pkg::UHFI_ST_RUN) && i_run && bit_en
      && s_r.left == 14'h0000 |=> s_r.tog == $past(cnt.interval_toggle))
      else $error("Remaining toggle not copied");
   a_budget_load: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_r.sof |-> s_r.budget == $past(cnt.packet_bit_budget))
      else $error("Packet budget not loaded at frame start");
endmodule
`default_nettype wire

// ===== core/uhfi_regs.sv
// Interrupt mask clear and frame length registers on the command port.
// Assumes host command strobes and event flags are synchronous to i_clk_sys.
//
// Summary of operation
// - Writing one clears matching enable bit
// - Writing zero leaves enable bit unchanged
// - Clear register reads back the mask
// - Mask clear uses codes 05 and 85
// - Bit 31 one clears master gate
// - Master gate reads set after reset
// - Event bits 6,5,4,3,2,0; others reserved
// - Frame length uses codes 0D and 8D
// - Fourteen-bit frame length in bits 13:0
// - Frame length defaults to 11999
// - Soft reset restores default frame length
// - Budget loaded into counter each frame
// - Interrupt needs flag, enable and master
// - Counter reloads from length at zero
// - Toggle copied to remaining toggle
`timescale 1ns/1ps
`default_nettype none
module uhfi_regs (
   // Clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   // Command port
   input wire logic i_cmd_valid,
   input wire logic [7:0] i_cmd_code,
   input wire logic [31:0] i_wdata,
   output logic [31:0] o_rdata,
   output logic o_rvalid,
   // Controller control
   input wire logic i_controller_soft_reset,
   input wire logic i_run,
   // Events and interrupt
   input wire logic [31:0] i_irq_event_flags,
   output logic o_irq,
   // Frame counter state
   output logic [13:0] o_frame_bits_left,
   output logic o_remaining_toggle,
   output logic [14:0] o_packet_budget_counter,
   output logic o_frame_start_event
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [31:0] mask;
      logic [31:0] flc;
      logic [31:0] rdata;
      logic rvalid;
      logic irq;
   } uhfi_regs_t;
   uhfi_regs_t s_r, s_nxt;
   logic wr_mask, wr_flc, rd_mask, rd_flc;

   uhfi_cnt_if cif ();

   uhfi_frame_cnt u_cnt (
      .i_clk_sys(i_clk_sys),
      .i_rst_n(i_rst_n),
      .i_run(i_run),
      .cnt(cif.cnt)
   );

   // Only defined bits survive a write
   function automatic logic [31:0] keep_defined(input logic [31:0] v);
      keep_defined = v & (uhfi_pkg::MASK_EVENT_BITS
         | (32'h1 << uhfi_pkg::MASTER_BIT));
   endfunction

   // Command decode, shared by all four strobes
   function automatic logic cmd_hit(input logic valid, input logic [7:0] code,
      input logic [7:0] want);
      cmd_hit = valid && (code == want);
   endfunction

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   assign rd_mask =
      cmd_hit(i_cmd_valid, i_cmd_code, uhfi_pkg::CMD_MASK_RD);
   assign wr_mask =
      cmd_hit(i_cmd_valid, i_cmd_code, uhfi_pkg::CMD_MASK_WR);
   assign rd_flc =
      cmd_hit(i_cmd_valid, i_cmd_code, uhfi_pkg::CMD_FLC_RD);
   assign wr_flc =
      cmd_hit(i_cmd_valid, i_cmd_code, uhfi_pkg::CMD_FLC_WR);

   always_comb begin
      s_nxt = s_r;
      s_nxt.rvalid = rd_mask || rd_flc;
      if (wr_mask) begin
         // Zeros keep bits, ones clear them, including master
         s_nxt.mask = s_r.mask & ~keep_defined(i_wdata);
      end
      if (wr_flc) begin
         s_nxt.flc = i_wdata & 32'hffff3fff;
      end
      // Soft reset wins over a same-cycle write for length bits 13:0 and the master bit
      if (i_controller_soft_reset) begin
         s_nxt.flc[uhfi_pkg::LEN_W-1:0] = uhfi_pkg::LEN_DEFAULT;
         // Master gate comes back set, as after power-up
         s_nxt.mask[uhfi_pkg::MASTER_BIT] = 1'b1;
      end
      if (rd_mask) begin
         s_nxt.rdata = s_r.mask;
      end else if (rd_flc) begin
         s_nxt.rdata = s_r.flc;
      end
      // Event enables reset clear and nothing here sets them,
      // so the request stays low until an enable source is added
      s_nxt.irq = s_r.mask[uhfi_pkg::MASTER_BIT]
         && |(i_irq_event_flags & s_r.mask
         & uhfi_pkg::MASK_EVENT_BITS);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         // Master gate set after hardware reset
         s_r <= '{uhfi_pkg::MASK_RST, uhfi_pkg::FLC_RST, 32'h00000000,
            1'b0, 1'b0};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign cif.frame_length = s_r.flc[uhfi_pkg::LEN_W-1:0];
   assign cif.interval_toggle = s_r.flc[uhfi_pkg::TOGGLE_BIT];
   assign cif.packet_bit_budget =
      s_r.flc[uhfi_pkg::BUDGET_LSB +: uhfi_pkg::BUDGET_W];
   assign o_rdata = s_r.rdata;
   assign o_rvalid = s_r.rvalid;
   assign o_irq = s_r.irq;
   assign o_frame_bits_left = cif.frame_bits_left;
   assign o_remaining_toggle = cif.remaining_toggle;
   assign o_packet_budget_counter = cif.packet_budget_counter;
   assign o_frame_start_event = cif.frame_start_event;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // A soft reset in the same cycle overrides the master bit of a mask write
   sequence s_mask_write;
      wr_mask && !i_controller_soft_reset;
   endsequence
   sequence s_clear_write;
      s_mask_write ##0 i_wdata[uhfi_pkg::MASTER_BIT];
   endsequence
   sequence s_any_read;
      rd_mask || rd_flc;
   endsequence
   sequence s_len_write;
      wr_flc && !i_controller_soft_reset;
   endsequence
   sequence s_mask_idle;
      !wr_mask && !i_controller_soft_reset;
   endsequence

   a_clear_bit: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_mask_write |=> (s_r.mask & $past(i_wdata) & 32'h8000007d) == 0)
      else $error("Written one did not clear enable");
   a_zero_keeps: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_mask_write |=> (s_r.mask & ~$past(i_wdata))
      == ($past(s_r.mask) & ~$past(i_wdata)))
      else $error("Written zero changed enable");
   a_master_clr: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_clear_write |=> ##1 !o_irq)
      else $error("Master clear did not block interrupt");
   a_read_mask: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      rd_mask |=> o_rvalid && o_rdata == $past(s_r.mask))
      else $error("Mask read returned wrong value");
   a_irq_gate: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      o_irq |-> $past(s_r.mask[31]) && $past(|(i_irq_event_flags
      & s_r.mask & 32'h0000007d)))
      else $error("Interrupt without enabled flag");
   a_soft_rst: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_controller_soft_reset |=> s_r.flc[13:0] == uhfi_pkg::LEN_DEFAULT)
      else $error("Soft reset did not restore length");
   a_reserved: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_r.flc[15:14] == 2'b00 && (s_r.mask & 32'h7fffff82) == 0)
      else $error("Reserved bits not zero");
   a_rst_mask: assert property (
      @(posedge i_clk_sys)
      $rose(i_rst_n) |-> s_r.mask[31])
      else $error("Master gate clear after reset");

   // ----------------------------------------
   // Answer, landing and gating checks
   // ----------------------------------------
   a_read_flc: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      rd_flc |=> o_rvalid && o_rdata == $past(s_r.flc))
      else $error("Frame length read returned wrong value");
   a_rvalid_pulse: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_any_read |=> o_rvalid)
      else $error("Read gave no answer");
   a_no_answer: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !(rd_mask || rd_flc) |=> !o_rvalid)
      else $error("Answer without a read code");
   a_rdata_holds: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !(rd_mask || rd_flc) |=> $stable(o_rdata))
      else $error("Read data changed without a read");
   a_len_write: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_len_write |=> s_r.flc == ($past(i_wdata) & 32'hffff3fff))
      else $error("Frame length write did not land");
   a_toggle_kept: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_len_write |=> cif.interval_toggle
      == $past(i_wdata[uhfi_pkg::TOGGLE_BIT]))
      else $error("Interval toggle not stored");
   a_mask_held: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      s_mask_idle |=> s_r.mask == $past(s_r.mask))
      else $error("Mask changed without a write");
   a_soft_master: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      i_controller_soft_reset |=> s_r.mask[uhfi_pkg::MASTER_BIT])
      else $error("Master gate clear after soft reset");
   a_gate_blocks: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !s_r.mask[uhfi_pkg::MASTER_BIT] |=> !o_irq)
      else $error("Interrupt with master gate clear");
   a_irq_event: assert property (
      @(posedge i_clk_sys) disable iff (!i_rst_n)
      !(|(i_irq_event_flags & s_r.mask & uhfi_pkg::MASK_EVENT_BITS))
      |=> !o_irq)
      else $error("Interrupt without an enabled event");
   a_rst_length: assert property (
      @(posedge i_clk_sys)
      $rose(i_rst_n) |-> s_r.flc == uhfi_pkg::FLC_RST)
      else $error("Frame length not default after reset");
endmodule
`default_nettype wire

// ===== tb/usb_host_irq_mask_frame_interval_bench.sv
// Self-checking bench for the mask clear and frame length registers.
// Assumes uhfi_regs and uhfi_pkg are compiled first; one 200 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module usb_host_irq_mask_frame_interval_bench;
   // ----------------------------------------
   // Stimulus and design
   // ----------------------------------------
   `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin fails++; \
      $display("wrong value at %0t: got %h expected %h", $time, a, b); end end
   logic i_clk_sys = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_cmd_valid = 1'b0;
   logic [7:0] i_cmd_code = 8'h00;
   logic [31:0] i_wdata = 32'h00000000;
   logic i_controller_soft_reset = 1'b0;
   logic i_run = 1'b0;
   logic [31:0] i_irq_event_flags = 32'h00000000;
   logic [31:0] o_rdata;
   logic o_rvalid;
   logic o_irq;
   logic [13:0] o_frame_bits_left;
   logic o_remaining_toggle;
   logic [14:0] o_packet_budget_counter;
   logic o_frame_start_event;
   int fails = 0;
   int tests_run = 0;
   always #2.5 i_clk_sys = ~i_clk_sys;
   uhfi_regs i_uhfi_regs (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid),
      .i_cmd_code(i_cmd_code), .i_wdata(i_wdata), .o_rdata(o_rdata),
      .o_rvalid(o_rvalid),
      .i_controller_soft_reset(i_controller_soft_reset), .i_run(i_run),
      .i_irq_event_flags(i_irq_event_flags), .o_irq(o_irq),
      .o_frame_bits_left(o_frame_bits_left),
      .o_remaining_toggle(o_remaining_toggle),
      .o_packet_budget_counter(o_packet_budget_counter),
      .o_frame_start_event(o_frame_start_event)
   );
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   // One-cycle command pulse; answer settles just after the taking edge
   task automatic cmd(input logic [7:0] code, input logic [31:0] data);
      @(posedge i_clk_sys);
      i_cmd_valid <= 1'b1;
      i_cmd_code <= code;
      i_wdata <= data;
      @(posedge i_clk_sys);
      i_cmd_valid <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [7:0] code, input logic [31:0] exp);
      cmd(code, 32'h00000000);
      `CHK(o_rvalid, 1'b1)
      `CHK(o_rdata, exp)
   endtask
   // Bounded wait, frames are short here
   task automatic wait_sof();
      for (int n = 0; n < 200; n++) begin
         @(posedge i_clk_sys);
         #1;
         if (o_frame_start_event === 1'b1) break;
      end
      `CHK(o_frame_start_event, 1'b1)
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset_values();
      rd(uhfi_pkg::CMD_MASK_RD, 32'h80000000);
      rd(uhfi_pkg::CMD_FLC_RD, 32'h00002edf);
   endtask
   task automatic t_mask_clear();
      @(posedge i_clk_sys);
      i_irq_event_flags <= 32'hffffffff;
      cmd(uhfi_pkg::CMD_MASK_WR, 32'h00000000);
      rd(uhfi_pkg::CMD_MASK_RD, 32'h80000000);
      `CHK(o_irq, 1'b0)
      cmd(uhfi_pkg::CMD_MASK_WR, 32'h7fffffff);
      rd(uhfi_pkg::CMD_MASK_RD, 32'h80000000);
      cmd(uhfi_pkg::CMD_MASK_WR, 32'h80000000);
      rd(uhfi_pkg::CMD_MASK_RD, 32'h00000000);
      // Unknown code gives no answer
      cmd(8'h04, 32'h00000000);
      `CHK(o_rvalid, 1'b0)
   endtask
   task automatic t_length_fields();
      cmd(uhfi_pkg::CMD_FLC_WR, 32'hffffffff);
      rd(uhfi_pkg::CMD_FLC_RD, 32'hffff3fff);
      @(posedge i_clk_sys);
      i_controller_soft_reset <= 1'b1;
      @(posedge i_clk_sys);
      i_controller_soft_reset <= 1'b0;
      rd(uhfi_pkg::CMD_FLC_RD, 32'hffff2edf);
      rd(uhfi_pkg::CMD_MASK_RD, 32'h80000000);
   endtask
   task automatic t_frames();
      // Short frame of 4 bit times keeps the run brief
      cmd(uhfi_pkg::CMD_FLC_WR, 32'h12340003);
      rd(uhfi_pkg::CMD_FLC_RD, 32'h12340003);
      @(posedge i_clk_sys);
      i_run <= 1'b1;
      wait_sof();
      `CHK(o_packet_budget_counter, 15'h1234)
      wait_sof();
      `CHK(o_remaining_toggle, 1'b0)
      `CHK(o_frame_bits_left, 14'h0003)
      cmd(uhfi_pkg::CMD_FLC_WR, 32'h85670002);
      wait_sof();
      wait_sof();
      `CHK(o_remaining_toggle, 1'b1)
      `CHK(o_packet_budget_counter, 15'h0567)
      `CHK(o_frame_bits_left, 14'h0002)
      @(posedge i_clk_sys);
      i_run <= 1'b0;
   endtask
   // ----------------------------------------
   // Sequence, watchdog and verdict
   // ----------------------------------------
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge i_clk_sys);
      i_rst_n <= 1'b1;
      t_reset_values();
      t_mask_clear();
      t_length_fields();
      t_frames();
      print_verdict();
   end
   // Whole run needs a few hundred cycles
   initial begin
      #100000;
      fails++;
      print_verdict();
   end
endmodule
`default_nettype wire
